// *** verilog/mrg_register_guard.sv ***
// Summary of operation
// - A write to a valid register while write mode is off is answered with exception 2.
// - A legal but out-of-range written value gets a normal answer and leaves the setting unchanged.
// - When the write-enable period runs out, write mode ends and the prior configuration comes back.
// - The address of the last holding register written out of range is readable at input register 30028.
// - The device stays silent when disabled or when the station address does not match; the master must match.
// - Float halves are ordered by the word-order setting, which the master must share.
// - String characters are packed by the string-order setting, which the master must share.
module mrg_register_guard
    import mrg_pkg::*;
#(
    parameter int unsigned WE_PERIOD_MS = 60000
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        modbus_en_i,
    input  wire logic [7:0]  station_addr_i,
    input  wire logic        word_order_i,
    input  wire logic        string_order_i,
    input  wire logic        we_unlock_i,
    input  wire logic [31:0] meas_float_i,
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_station_i,
    input  wire logic [7:0]  req_func_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [15:0] req_count_i,
    input  wire logic [31:0] req_wdata_i,
    output logic             resp_valid_o,
    output logic [7:0]       resp_byte_o,
    output logic             resp_last_o,
    output logic             busy_o,
    output logic             we_active_o,
    output logic [31:0]      cfg_float_o,
    output logic [31:0]      cfg_str_o,
    output logic [15:0]      cfg_set_o
);

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint unsigned WE_CYCLES_L = (64'(WE_PERIOD_MS) * REF_CLK_HZ) / 64'(MS_PER_S);
    localparam logic [31:0]     WE_CYCLES   = (WE_CYCLES_L < 64'd1) ? 32'h0000_0001 : WE_CYCLES_L[31:0];

    mrg_regs_t r;
    mrg_regs_t next_r;
    logic [7:0]  cur_byte;
    logic [15:0] crc_next;

    mrg_crc16 u_crc (
        .crc_i  (r.crc),
        .byte_i (cur_byte),
        .crc_o  (crc_next)
    );

    assign cur_byte = r.frame[r.idx[2:0]];

    // ****************************************************************
    // Request decode, configuration and response framing
    // ****************************************************************
    always_comb begin
        logic [1:0]  item;
        logic [31:0] rd;
        logic [31:0] wv;
        logic [7:0]  exc;
        logic        ok_func;
        logic        in_range;
        item     = IT_NONE;
        rd       = 32'h0000_0000;
        wv       = 32'h0000_0000;
        exc      = 8'h00;
        ok_func  = 1'b1;
        in_range = 1'b1;
        next_r   = r;
        next_r.resp_valid = 1'b0;
        next_r.resp_last  = 1'b0;

        case (r.st)
            ST_IDLE: begin
                // Only addressed, enabled traffic is answered
                if (req_valid_i && modbus_en_i && (req_station_i == station_addr_i)) begin
                    next_r.frame[0] = station_addr_i;
                    next_r.frame[1] = req_func_i;
                    case (req_func_i)
                        FN_READ_HOLD, FN_WRITE_ONE, FN_WRITE_MANY: begin
                            item = mrg_hold_item(req_addr_i);
                        end
                        FN_READ_INPUT: begin
                            if (req_addr_i == IN_MEAS_ADDR) begin
                                item = IT_FLOAT;
                            end else if (req_addr_i == IN_OOR_ADDR) begin
                                item = IT_SET;
                            end
                        end
                        default: begin
                            ok_func = 1'b0;
                        end
                    endcase
                    // Partial coverage of a multi-register value is refused
                    if (!ok_func) begin
                        exc = EXC_ILLEGAL_FUNC;
                    end else if (item == IT_NONE || req_count_i != {8'h00, mrg_item_regs(item)}) begin
                        exc = EXC_ILLEGAL_ADDR;
                    end else if (req_func_i == FN_WRITE_ONE && item != IT_SET) begin
                        exc = EXC_ILLEGAL_ADDR;
                    end else if ((req_func_i == FN_WRITE_ONE || req_func_i == FN_WRITE_MANY) && !r.we_on) begin
                        exc = EXC_ILLEGAL_ADDR;
                    end

                    if (exc != 8'h00) begin
                        next_r.frame[1] = req_func_i | EXC_FLAG;
                        next_r.frame[2] = exc;
                        next_r.len      = LEN_EXC;
                    end else if (req_func_i == FN_READ_HOLD || req_func_i == FN_READ_INPUT) begin
                        if (req_func_i == FN_READ_INPUT) begin
                            rd = (item == IT_FLOAT) ? mrg_word_order(meas_float_i, word_order_i)
                                                    : {r.last_oor, 16'h0000};
                        end else if (item == IT_FLOAT) begin
                            rd = mrg_word_order(r.cfg_float, word_order_i);
                        end else if (item == IT_STR) begin
                            rd = mrg_str_order(r.cfg_str, string_order_i);
                        end else begin
                            rd = {r.cfg_set, 16'h0000};
                        end
                        next_r.frame[2] = 8'(mrg_item_regs(item) << 1);
                        next_r.frame[3] = rd[31:24];
                        next_r.frame[4] = rd[23:16];
                        next_r.frame[5] = rd[15:8];
                        next_r.frame[6] = rd[7:0];
                        next_r.len      = 4'(3 + 2 * mrg_item_regs(item));
                    end else begin
                        // Write echo: address then value or quantity
                        next_r.frame[2] = req_addr_i[15:8];
                        next_r.frame[3] = req_addr_i[7:0];
                        next_r.frame[4] = (req_func_i == FN_WRITE_ONE) ? req_wdata_i[15:8] : req_count_i[15:8];
                        next_r.frame[5] = (req_func_i == FN_WRITE_ONE) ? req_wdata_i[7:0] : req_count_i[7:0];
                        next_r.len      = LEN_WRITE;
                        if (item == IT_FLOAT) begin
                            wv       = mrg_word_order(req_wdata_i, word_order_i);
                            in_range = !wv[31] && (wv[30:23] <= FLT_EXP_MAX);
                        end else if (item == IT_STR) begin
                            wv       = mrg_str_order(req_wdata_i, string_order_i);
                        end else begin
                            wv       = {16'h0000, (req_func_i == FN_WRITE_ONE) ? req_wdata_i[15:0] : req_wdata_i[31:16]};
                            in_range = (wv[15:0] >= SET_MIN) && (wv[15:0] <= SET_MAX);
                        end
                        // Normal answer either way; only in-range values are stored
                        if (!in_range) begin
                            next_r.last_oor = req_addr_i;
                        end else if (item == IT_FLOAT) begin
                            next_r.cfg_float = wv;
                        end else if (item == IT_STR) begin
                            next_r.cfg_str = wv;
                        end else begin
                            next_r.cfg_set = wv[15:0];
                        end
                    end
                    next_r.idx  = 4'h0;
                    next_r.crc  = CRC_INIT;
                    next_r.busy = 1'b1;
                    next_r.st   = ST_SEND;
                end
            end
            ST_SEND: begin
                // CRC goes out low byte first
                next_r.resp_valid = 1'b1;
                next_r.idx        = r.idx + 4'h1;
                if (r.idx < r.len) begin
                    next_r.resp_byte = cur_byte;
                    next_r.crc       = crc_next;
                end else if (r.idx == r.len) begin
                    next_r.resp_byte = r.crc[7:0];
                end else begin
                    next_r.resp_byte = r.crc[15:8];
                    next_r.resp_last = 1'b1;
                    next_r.busy      = 1'b0;
                    next_r.st        = ST_IDLE;
                end
            end
            default: begin
                next_r.st   = ST_IDLE;
                next_r.busy = 1'b0;
            end
        endcase

        // ****************************************************************
        // Write-enable period
        // ****************************************************************
        // Expiry is applied last so the restore wins over a write in the same cycle
        if (we_unlock_i) begin
            if (!r.we_on) begin
                next_r.bak_float = r.cfg_float;
                next_r.bak_str   = r.cfg_str;
                next_r.bak_set   = r.cfg_set;
            end
            next_r.we_on    = 1'b1;
            next_r.we_timer = WE_CYCLES - 32'h0000_0001;
        end else if (r.we_on) begin
            if (r.we_timer == 32'h0000_0000) begin
                next_r.we_on     = 1'b0;
                next_r.cfg_float = r.bak_float;
                next_r.cfg_str   = r.bak_str;
                next_r.cfg_set   = r.bak_set;
            end else begin
                next_r.we_timer = r.we_timer - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r            <= '0;
            r.st         <= ST_IDLE;
            r.crc        <= CRC_INIT;
            r.cfg_float  <= CFG_FLOAT_RST;
            r.cfg_str    <= CFG_STR_RST;
            r.cfg_set    <= CFG_SET_RST;
            r.bak_float  <= CFG_FLOAT_RST;
            r.bak_str    <= CFG_STR_RST;
            r.bak_set    <= CFG_SET_RST;
            r.last_oor   <= OOR_ADDR_RST;
        end else begin
            r <= next_r;
        end
    end

    assign resp_valid_o = r.resp_valid;
    assign resp_byte_o  = r.resp_byte;
    assign resp_last_o  = r.resp_last;
    assign busy_o       = r.busy;
    assign we_active_o  = r.we_on;
    assign cfg_float_o  = r.cfg_float;
    assign cfg_str_o    = r.cfg_str;
    assign cfg_set_o    = r.cfg_set;

endmodule : mrg_register_guard

// *** shared/mrg_pkg.sv ***
package mrg_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam longint unsigned REF_CLK_HZ     = 64'd20_000_000;
    localparam int unsigned     MS_PER_S       = 1000;

    // ****************************************************************
    // Function and exception codes
    // ****************************************************************
    localparam logic [7:0] FN_READ_HOLD     = 8'h03;
    localparam logic [7:0] FN_READ_INPUT    = 8'h04;
    localparam logic [7:0] FN_WRITE_ONE     = 8'h06;
    localparam logic [7:0] FN_WRITE_MANY    = 8'h10;
    localparam logic [7:0] EXC_FLAG         = 8'h80;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

    // ****************************************************************
    // Register addresses (protocol addresses)
    // ****************************************************************
    localparam logic [15:0] HOLD_FLOAT_ADDR = 16'h0000;
    localparam logic [15:0] HOLD_STR_ADDR   = 16'h0002;
    localparam logic [15:0] HOLD_SET_ADDR   = 16'h0004;
    localparam logic [15:0] IN_MEAS_ADDR    = 16'h7530;
    localparam logic [15:0] IN_OOR_ADDR     = 16'h754C;

    // ****************************************************************
    // Reset values and permitted ranges
    // ****************************************************************
    localparam logic [31:0] CFG_FLOAT_RST   = 32'h0000_0000;
    localparam logic [31:0] CFG_STR_RST     = 32'h2020_2020;
    localparam logic [15:0] CFG_SET_RST     = 16'h0001;
    localparam logic [15:0] SET_MIN         = 16'h0001;
    localparam logic [15:0] SET_MAX         = 16'h0064;
    localparam logic [7:0]  FLT_EXP_MAX     = 8'h85;
    localparam logic [15:0] OOR_ADDR_RST    = 16'h0000;
    localparam logic [15:0] CRC_INIT        = 16'hFFFF;
    localparam logic [15:0] CRC_POLY        = 16'hA001;

    // ****************************************************************
    // Item codes and frame sizes
    // ****************************************************************
    localparam logic [1:0]  IT_NONE         = 2'h0;
    localparam logic [1:0]  IT_FLOAT        = 2'h1;
    localparam logic [1:0]  IT_STR          = 2'h2;
    localparam logic [1:0]  IT_SET          = 2'h3;
    localparam int unsigned FRAME_BYTES     = 7;
    localparam logic [3:0]  LEN_EXC         = 4'h3;
    localparam logic [3:0]  LEN_WRITE       = 4'h6;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } mrg_state_t;

    typedef struct packed {
        mrg_state_t                   st;
        logic [FRAME_BYTES-1:0][7:0]  frame;
        logic [3:0]                   len;
        logic [3:0]                   idx;
        logic [15:0]                  crc;
        logic [31:0]                  cfg_float;
        logic [31:0]                  cfg_str;
        logic [15:0]                  cfg_set;
        logic [31:0]                  bak_float;
        logic [31:0]                  bak_str;
        logic [15:0]                  bak_set;
        logic                         we_on;
        logic [31:0]                  we_timer;
        logic [15:0]                  last_oor;
        logic                         resp_valid;
        logic [7:0]                   resp_byte;
        logic                         resp_last;
        logic                         busy;
    } mrg_regs_t;

    // Holding item starting exactly at addr, or none
    function automatic logic [1:0] mrg_hold_item(input logic [15:0] addr);
        case (addr)
            HOLD_FLOAT_ADDR: mrg_hold_item = IT_FLOAT;
            HOLD_STR_ADDR:   mrg_hold_item = IT_STR;
            HOLD_SET_ADDR:   mrg_hold_item = IT_SET;
            default:         mrg_hold_item = IT_NONE;
        endcase
    endfunction : mrg_hold_item

    function automatic logic [7:0] mrg_item_regs(input logic [1:0] item);
        mrg_item_regs = (item == IT_SET) ? 8'h01 : ((item == IT_NONE) ? 8'h00 : 8'h02);
    endfunction : mrg_item_regs

    // Word order: swap=1 puts the low half in the first register
    function automatic logic [31:0] mrg_word_order(input logic [31:0] v, input logic swap);
        mrg_word_order = swap ? {v[15:0], v[31:16]} : v;
    endfunction : mrg_word_order

    // String order: swap=1 puts the first character in the low byte
    function automatic logic [31:0] mrg_str_order(input logic [31:0] v, input logic swap);
        mrg_str_order = swap ? {v[23:16], v[31:24], v[7:0], v[15:8]} : v;
    endfunction : mrg_str_order

endpackage : mrg_pkg

// *** verilog/mrg_crc16.sv ***
module mrg_crc16
    import mrg_pkg::*;
(
    input  wire logic [15:0] crc_i,
    input  wire logic [7:0]  byte_i,
    output logic      [15:0] crc_o
);

    always_comb begin
        logic [15:0] c;
        c = crc_i ^ {8'h00, byte_i};
        for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        crc_o = c;
    end

endmodule : mrg_crc16

// *** verification/mrg_register_guard_sva.sv ***
module mrg_register_guard_sva
    import mrg_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        modbus_en_i,
    input  wire logic [7:0]  station_addr_i,
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_station_i,
    input  wire logic [7:0]  req_func_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [31:0] req_wdata_i,
    input  wire logic        resp_valid_o,
    input  wire logic [7:0]  resp_byte_o,
    input  wire logic        resp_last_o,
    input  wire logic        busy_o,
    input  wire logic        we_active_o,
    input  wire logic [15:0] cfg_set_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    assign take = req_valid_i && !busy_o && modbus_en_i && (req_station_i == station_addr_i);
    // ****************************************************************
    // Properties
    // ****************************************************************
    // ****************************************************************
    busy_rise_a: assert property (take |=> busy_o) else $error("busy missing after request");
    stn_echo_a: assert property (take |-> ##2 resp_valid_o && resp_byte_o == $past(req_station_i, 2))
        else $error("first byte is not the station");
    func_echo_a: assert property (take |-> ##3 resp_byte_o[6:0] == ($past(req_func_i, 3) & 8'h7F))
        else $error("function byte not echoed");
    write_off_a: assert property (take && req_func_i == FN_WRITE_ONE && !we_active_o
        |-> ##3 resp_byte_o == (FN_WRITE_ONE | EXC_FLAG) ##1 resp_byte_o == EXC_ILLEGAL_ADDR)
        else $error("locked write not refused");
    quiet_off_a: assert property (req_valid_i && !busy_o && !resp_valid_o && !modbus_en_i
        |=> !busy_o ##1 !resp_valid_o) else $error("answer while disabled");
    quiet_stn_a: assert property (req_valid_i && !busy_o && !resp_valid_o
        && req_station_i != station_addr_i |=> !busy_o ##1 !resp_valid_o) else $error("answer to other station");
    last_free_a: assert property (resp_last_o |-> resp_valid_o && !busy_o) else $error("last byte framing");
    in_frame_a: assert property (resp_valid_o && !resp_last_o |-> busy_o) else $error("byte outside busy");
    frame_len_a: assert property ($rose(busy_o) |-> ##[5:9] resp_last_o) else $error("frame length wrong");
    set_hold_a: assert property ($changed(cfg_set_o) |-> $past(we_active_o)) else $error("setting changed locked");
    oor_keep_a: assert property (take && req_func_i == FN_WRITE_ONE && req_addr_i == HOLD_SET_ADDR
        && req_wdata_i[15:0] > SET_MAX |=> $stable(cfg_set_o) || !we_active_o) else $error("range not kept");
    cover property (take && req_func_i == FN_WRITE_MANY);
    cover property ($fell(we_active_o));
    cover property (resp_valid_o && resp_byte_o == (FN_READ_HOLD | EXC_FLAG));
endmodule : mrg_register_guard_sva

// *** verification/mrg_master_model.sv ***
module mrg_master_model
    import mrg_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       last_i,
    input  wire logic       clr_i,
    output logic [7:0]      rx_o [0:15],
    output logic [4:0]      n_o,
    output logic            done_o,
    output logic            crc_ok_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] crc;
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        return c;
    endfunction : crc_step
    // Residue over frame plus its CRC is zero when the CRC is right
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i || clr_i) begin
            n_o <= 5'h00;
            done_o <= 1'b0;
            crc_ok_o <= 1'b0;
            crc <= CRC_INIT;
        end else if (valid_i) begin
            if (n_o < 5'h10) rx_o[n_o[3:0]] <= byte_i;
            n_o <= n_o + 5'h01;
            crc <= crc_step(crc, byte_i);
            if (last_i) begin
                done_o <= 1'b1;
                crc_ok_o <= (crc_step(crc, byte_i) == 16'h0000);
            end
        end
    end
endmodule : mrg_master_model

// *** verification/mrg_register_guard_tb.sv ***
module mrg_register_guard_tb
    import mrg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct { logic [7:0] f; logic [15:0] a; logic [15:0] c; logic [31:0] w; int n; logic [47:0] p; } mrg_row_t;
    logic ref_clk, rst_n, en, unl, wo, so, rv, clr, rvo, rlo, busy, wea, done, crc_ok;
    logic [7:0] stn, rs, rf, rbo;
    logic [7:0] rx [0:15];
    logic [4:0] nrx;
    logic [15:0] ra, rc, cfset;
    logic [31:0] rw, meas, cff, cfs;
    int n_fail, total_checks, cyc, k, t0;
    mrg_row_t rows [10];
    mrg_register_guard #(.WE_PERIOD_MS(1)) dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .modbus_en_i(en),
        .station_addr_i(stn), .word_order_i(wo), .string_order_i(so), .we_unlock_i(unl), .meas_float_i(meas),
        .req_valid_i(rv), .req_station_i(rs), .req_func_i(rf), .req_addr_i(ra), .req_count_i(rc),
        .req_wdata_i(rw), .resp_valid_o(rvo), .resp_byte_o(rbo), .resp_last_o(rlo), .busy_o(busy),
        .we_active_o(wea), .cfg_float_o(cff), .cfg_str_o(cfs), .cfg_set_o(cfset));
    mrg_master_model mdl (.clk_i(ref_clk), .rst_n_i(rst_n), .valid_i(rvo), .byte_i(rbo), .last_i(rlo),
        .clr_i(clr), .rx_o(rx), .n_o(nrx), .done_o(done), .crc_ok_o(crc_ok));
    task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c, input logic [31:0] w);
        @(posedge ref_clk);
        rf <= f; ra <= a; rc <= c; rw <= w; rv <= 1'b1; clr <= 1'b1;
        @(posedge ref_clk);
        rv <= 1'b0; clr <= 1'b0;
        #1;
    endtask : send
    task automatic chk(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c, input logic [31:0] w,
                       input int n, input logic [47:0] p);
        int i;
        send(f, a, c, w);
        i = 0;
        while (done !== 1'b1 && i < 30) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        cmp("frame length", 48'(n + 3), 48'(nrx));
        cmp("frame crc", 48'h1, 48'(crc_ok));
        cmp("station byte", 48'(stn), 48'(rx[0]));
        for (i = 0; i < n; i++) cmp("reply byte", 48'(p[8*(n-1-i) +: 8]), 48'(rx[i+1]));
        // Return on an edge so later input changes land on the rising edge
        @(posedge ref_clk);
    endtask : chk
    task automatic unlock();
        @(posedge ref_clk);
        unl <= 1'b1;
        @(posedge ref_clk);
        unl <= 1'b0;
    endtask : unlock
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Ceiling covers one 20000-cycle write window plus traffic
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        rst_n = 1'b0; en = 1'b1; unl = 1'b0; wo = 1'b0; so = 1'b0; rv = 1'b0; clr = 1'b0;
        stn = 8'h11; rs = 8'h11; rf = 8'h00; ra = 16'h0000; rc = 16'h0000; rw = 32'h0; meas = 32'h4120_0000;
        n_fail = 0; total_checks = 0; cyc = 0;
        rows = '{'{FN_READ_HOLD, 16'h0000, 16'h0002, 32'h0, 6, 48'h0304_0000_0000},
                 '{FN_READ_HOLD, 16'h0002, 16'h0002, 32'h0, 6, 48'h0304_2020_2020},
                 '{FN_READ_HOLD, 16'h0004, 16'h0001, 32'h0, 4, 48'h0302_0001},
                 '{FN_READ_HOLD, 16'h0000, 16'h0001, 32'h0, 2, 48'h8302},
                 '{FN_READ_HOLD, 16'h0001, 16'h0002, 32'h0, 2, 48'h8302},
                 '{8'h01, 16'h0000, 16'h0001, 32'h0, 2, 48'h8101},
                 '{FN_WRITE_ONE, 16'h0004, 16'h0001, 32'h10, 2, 48'h8602},
                 '{FN_WRITE_MANY, 16'h0000, 16'h0002, 32'h3F80_0000, 2, 48'h9002},
                 '{FN_READ_INPUT, 16'h754C, 16'h0001, 32'h0, 4, 48'h0402_0000},
                 '{FN_READ_INPUT, 16'h7530, 16'h0002, 32'h0, 6, 48'h0404_4120_0000}};
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) chk(rows[i].f, rows[i].a, rows[i].c, rows[i].w, rows[i].n, rows[i].p);
        // ****************************************************************
        // Silence, write window, orders, expiry, reset
        // ****************************************************************
        en <= 1'b0;
        send(FN_READ_HOLD, 16'h0004, 16'h0001, 32'h0);
        repeat (12) @(posedge ref_clk);
        cmp("disabled bytes", 48'h0, 48'(nrx));
        en <= 1'b1; rs <= 8'h12;
        send(FN_READ_HOLD, 16'h0004, 16'h0001, 32'h0);
        repeat (12) @(posedge ref_clk);
        cmp("other station bytes", 48'h0, 48'(nrx));
        rs <= 8'h11;
        unlock();
        t0 = cyc;
        chk(FN_WRITE_ONE, 16'h0004, 16'h0001, 32'h0032, 5, 48'h06_0004_0032);
        cmp("setting stored", 48'h0032, 48'(cfset));
        chk(FN_WRITE_ONE, 16'h0004, 16'h0001, 32'h0065, 5, 48'h06_0004_0065);
        cmp("setting kept", 48'h0032, 48'(cfset));
        chk(FN_READ_INPUT, 16'h754C, 16'h0001, 32'h0, 4, 48'h0402_0004);
        chk(FN_WRITE_MANY, 16'h0000, 16'h0002, 32'h3F80_0000, 5, 48'h10_0000_0002);
        cmp("float stored", 48'h3F80_0000, 48'(cff));
        // Exponent field above the permitted limit: normal answer, no store
        chk(FN_WRITE_MANY, 16'h0000, 16'h0002, 32'h4700_0000, 5, 48'h10_0000_0002);
        cmp("float kept", 48'h3F80_0000, 48'(cff));
        chk(FN_WRITE_MANY, 16'h0000, 16'h0001, 32'h0, 2, 48'h9002);
        chk(FN_WRITE_ONE, 16'h0000, 16'h0001, 32'h0, 2, 48'h8602);
        chk(FN_WRITE_MANY, 16'h0002, 16'h0002, 32'h4142_4344, 5, 48'h10_0002_0002);
        wo <= 1'b1;
        chk(FN_READ_HOLD, 16'h0000, 16'h0002, 32'h0, 6, 48'h0304_0000_3F80);
        so <= 1'b1;
        chk(FN_READ_HOLD, 16'h0002, 16'h0002, 32'h0, 6, 48'h0304_4241_4443);
        k = 0;
        while (wea === 1'b1 && k < 21000) begin
            @(posedge ref_clk);
            k++;
        end
        cmp("window length", 48'h1, 48'((cyc - t0 >= 19950) && (cyc - t0 <= 20005)));
        cmp("setting restored", 48'(CFG_SET_RST), 48'(cfset));
        cmp("float restored", 48'(CFG_FLOAT_RST), 48'(cff));
        cmp("string restored", 48'(CFG_STR_RST), 48'(cfs));
        chk(FN_WRITE_ONE, 16'h0004, 16'h0001, 32'h0010, 2, 48'h8602);
        unlock();
        chk(FN_WRITE_ONE, 16'h0004, 16'h0001, 32'h0010, 5, 48'h06_0004_0010);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        cmp("reset write mode", 48'h0, 48'(wea));
        cmp("reset setting", 48'(CFG_SET_RST), 48'(cfset));
        rst_n <= 1'b1;
        chk(FN_READ_HOLD, 16'h0004, 16'h0001, 32'h0, 4, 48'h0302_0001);
        report_and_stop();
    end
endmodule : mrg_register_guard_tb
bind mrg_register_guard mrg_register_guard_sva u_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .modbus_en_i(modbus_en_i), .station_addr_i(station_addr_i), .req_valid_i(req_valid_i),
    .req_station_i(req_station_i), .req_func_i(req_func_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .resp_valid_o(resp_valid_o), .resp_byte_o(resp_byte_o), .resp_last_o(resp_last_o), .busy_o(busy_o),
    .we_active_o(we_active_o), .cfg_set_o(cfg_set_o));
